// >>> verilog/usbep_dev.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "usbep_defines.svh"
// Contract
// R1 - serviced-out-ready write of one clears out-ready
// R2 - serviced-setup-end write of one clears setup-end
// R3 - control end without data-end sets setup-end
// R4 - send-stall cleared once stall handshake sent
// R5 - firmware marks last data; hardware clears it
// R6 - sent-stall set after stall, firmware clears
// R7 - in-ready cleared with event on send/setup/overwrite
// R8 - count register: bytes in 6:0, bit7 zero
// R9 - index picks one endpoint register set
// R10 - split bit opens both IN and OUT pipes
// R11 - unsplit endpoint uses direction-select bit
// R12 - disabled endpoint answers nothing, never stalls
// R13 - all endpoints enabled out of reset
// R14 - enable bits 3:1, upper ones, bit0 one
// R15 - writes to count register are ignored
module usbep_dev (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	usbep_if.dev bus,
	input wire logic ev_setup,
	input wire logic ev_out_rx,
	input wire usbep_pkg::usbep_cnt_t rx_count,
	input wire logic ev_in_sent,
	input wire logic ev_in_overwrite,
	input wire logic ev_stall_sent,
	input wire logic ev_ctrl_end,
	output logic ep0_out_ready,
	output logic ep0_in_ready,
	output logic ep0_stall,
	output logic [3:1] ep_live,
	output logic [3:1] ep_in_pipe,
	output logic [3:1] ep_out_pipe
);
	import usbep_pkg::*;

	function automatic logic hit(input usbep_byte_t a, input usbep_byte_t off);
		return a == off;
	endfunction

	logic [1:0] index_q;
	logic opr_q;
	logic ipr_q;
	logic sst_q;
	logic lde_q;
	logic sue_q;
	logic sds_q;
	usbep_cnt_t cnt_q;
	logic [3:1] een_q;
	usbep_byte_t inl_q [1:3];
	usbep_byte_t inh_q [1:3];
	usbep_byte_t outl_q [1:3];
	usbep_byte_t outh_q [1:3];
	logic ack_q;
	usbep_byte_t rdata_q;
	logic evt_q;
	logic [3:1] live_q;
	logic [3:1] inp_q;
	logic [3:1] outp_q;

	wire logic idx0 = index_q == `USBEP_IDX_EP0;
	wire logic [7:0] wd = bus.wdata;
	wire logic w_index = bus.wr & hit(bus.addr, `USBEP_A_INDEX);
	wire logic w_csr0 = bus.wr & idx0 & hit(bus.addr, `USBEP_A_CSRL);
	// [R9] only the indexed endpoint set takes writes
	wire logic w_inl = bus.wr & ~idx0 & hit(bus.addr, `USBEP_A_CSRL);
	wire logic w_inh = bus.wr & ~idx0 & hit(bus.addr, `USBEP_A_CSRH);
	wire logic w_outl = bus.wr & ~idx0 & hit(bus.addr, `USBEP_A_OUTL);
	wire logic w_outh = bus.wr & ~idx0 & hit(bus.addr, `USBEP_A_OUTH);
	wire logic w_enable = bus.wr & hit(bus.addr, `USBEP_A_ENABLE);

	// setup and out data both deliver a packet for firmware
	wire logic opr_set = ev_out_rx | ev_setup;
	wire logic opr_clr = w_csr0 & wd[`USBEP_B_SOPR]; // [R1]
	// hardware set wins over a clearing write in the same cycle
	wire logic opr_d = opr_set | (opr_q & ~opr_clr);

	wire logic sue_set = ev_ctrl_end & ~lde_q; // [R3]
	wire logic sue_clr = w_csr0 & wd[`USBEP_B_SSUE]; // [R2]
	wire logic sue_d = sue_set | (sue_q & ~sue_clr);

	// a fresh marker written with the end event survives it
	wire logic lde_wr = w_csr0 & wd[`USBEP_B_LDE];
	wire logic lde_d = lde_wr | (lde_q & ~ev_ctrl_end); // [R5]

	wire logic sds_wr = w_csr0 & wd[`USBEP_B_SDS];
	wire logic sds_d = sds_wr | (sds_q & ~ev_stall_sent); // [R4]

	// sent-stall is cleared by writing zero; the stall event wins
	wire logic sst_clr = w_csr0 & ~wd[`USBEP_B_SST];
	wire logic sst_d = ev_stall_sent | (sst_q & ~sst_clr); // [R6]

	wire logic ipr_drop = ev_in_sent | ev_setup | ev_in_overwrite;
	wire logic ipr_wr = w_csr0 & wd[`USBEP_B_IPR];
	// arming a new packet wins over the drop of the old one
	wire logic ipr_d = ipr_wr | (ipr_q & ~ipr_drop); // [R7]

	// one event pulse to the firmware side when hardware sets an ep0 flag or a set in-ready drops
	wire logic evt_d = (ipr_q & ipr_drop) | opr_set | ev_stall_sent | sue_set; // [R7]

	// count is latched only with a packet; no write path exists
	wire usbep_cnt_t cnt_d = opr_set ? rx_count : cnt_q; // [R15]

	wire logic [7:0] csr0_rd = {
		1'h0, 1'h0, sds_q, sue_q, lde_q, sst_q, ipr_q, opr_q
	};
	wire logic [7:0] cnt_rd = {1'b0, cnt_q}; // [R8]
	wire logic [7:0] en_rd = {`USBEP_EN_HI, een_q, `USBEP_RSV_ONE}; // [R14]
	wire logic [7:0] idx_rd = {6'h00, index_q};

	// [R9] banked registers visible only through the index
	wire logic [7:0] rd_mux =
		hit(bus.addr, `USBEP_A_INDEX) ? idx_rd :
		hit(bus.addr, `USBEP_A_CNT) ? cnt_rd :
		hit(bus.addr, `USBEP_A_ENABLE) ? en_rd :
		(idx0 & hit(bus.addr, `USBEP_A_CSRL)) ? csr0_rd :
		idx0 ? 8'h00 :
		hit(bus.addr, `USBEP_A_CSRL) ? inl_q[index_q] :
		hit(bus.addr, `USBEP_A_CSRH) ? inh_q[index_q] :
		hit(bus.addr, `USBEP_A_OUTL) ? outl_q[index_q] :
		hit(bus.addr, `USBEP_A_OUTH) ? outh_q[index_q] :
		8'h00;

	// pipe directions, gated by enable so a disabled endpoint is silent
	logic [3:1] live_d;
	logic [3:1] inp_d;
	logic [3:1] outp_d;
	always_comb begin
		for (int i = 1; i <= 3; i++) begin
			live_d[i] = een_q[i]; // [R12]
			inp_d[i] = een_q[i] & (inh_q[i][`USBEP_B_SPLIT] | inh_q[i][`USBEP_B_DIR]); // [R10] [R11]
			outp_d[i] = een_q[i] & (inh_q[i][`USBEP_B_SPLIT] | ~inh_q[i][`USBEP_B_DIR]); // [R10] [R11]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			opr_q <= 1'h0;
			ipr_q <= 1'h0;
			sst_q <= 1'h0;
			lde_q <= 1'h0;
			sue_q <= 1'h0;
			sds_q <= 1'h0;
			cnt_q <= '0;
		end else if (ce) begin
			opr_q <= opr_d;
			ipr_q <= ipr_d;
			sst_q <= sst_d;
			lde_q <= lde_d;
			sue_q <= sue_d;
			sds_q <= sds_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			index_q <= `USBEP_IDX_EP0;
			een_q <= `USBEP_EN_RST; // [R13]
		end else if (ce) begin
			if (w_index) begin
				index_q <= wd[1:0];
			end
			if (w_enable) begin
				een_q <= wd[3:1]; // [R14]
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 1; i <= 3; i++) begin
				inl_q[i] <= 8'h00;
				inh_q[i] <= 8'h00;
				outl_q[i] <= 8'h00;
				outh_q[i] <= 8'h00;
			end
		end else if (ce) begin
			if (w_inl) begin
				inl_q[index_q] <= wd;
			end
			if (w_inh) begin
				inh_q[index_q] <= wd;
			end
			if (w_outl) begin
				outl_q[index_q] <= wd;
			end
			if (w_outh) begin
				outh_q[index_q] <= wd;
			end
		end
	end

	// every access is answered one cycle later, mapped or not
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ack_q <= 1'h0;
			rdata_q <= 8'h00;
			evt_q <= 1'h0;
			live_q <= `USBEP_EN_RST;
			inp_q <= 3'h0;
			outp_q <= `USBEP_EN_RST;
		end else if (ce) begin
			ack_q <= bus.wr | bus.rd;
			if (bus.rd) begin
				rdata_q <= rd_mux;
			end
			evt_q <= evt_d;
			live_q <= live_d;
			inp_q <= inp_d;
			outp_q <= outp_d;
		end
	end

	assign bus.ack = ack_q;
	assign bus.rdata = rdata_q;
	assign bus.dev_evt = evt_q;
	assign ep0_out_ready = opr_q;
	assign ep0_in_ready = ipr_q;
	assign ep0_stall = sds_q; // [R4]
	assign ep_live = live_q;
	assign ep_in_pipe = inp_q;
	assign ep_out_pipe = outp_q;
endmodule

// >>> verilog/usbep_defines.svh
`ifndef USBEP_DEFINES_SVH
`define USBEP_DEFINES_SVH

// indexed register space of the endpoint block
`define USBEP_A_INDEX 8'h0E
`define USBEP_A_CSRL 8'h11
`define USBEP_A_CSRH 8'h12
`define USBEP_A_OUTL 8'h14
`define USBEP_A_OUTH 8'h15
`define USBEP_A_CNT 8'h16
`define USBEP_A_ENABLE 8'h1E

// endpoint 0 control/status bit positions (index 0 at USBEP_A_CSRL)
`define USBEP_B_OPR 0
`define USBEP_B_IPR 1
`define USBEP_B_SST 2
`define USBEP_B_LDE 3
`define USBEP_B_SUE 4
`define USBEP_B_SDS 5
`define USBEP_B_SOPR 6
`define USBEP_B_SSUE 7

// endpoint 1-3 high IN control bits
`define USBEP_B_SPLIT 2
`define USBEP_B_DIR 5

// endpoint enable register
`define USBEP_B_RSV 0
`define USBEP_EN_HI 4'hF
`define USBEP_EN_RST 3'h7
`define USBEP_RSV_ONE 1'h1
`define USBEP_IDX_EP0 2'h0

// avalon byte addresses of the controller registers
`define USBEP_AV_CMD 4'h0
`define USBEP_AV_STAT 4'h4
`define USBEP_AV_ISTS 4'h8
`define USBEP_AV_IMSK 4'hC

// field positions in the controller registers
`define USBEP_CMD_WR 16
`define USBEP_STAT_BUSY 8
`define USBEP_IRQ_DONE 0
`define USBEP_IRQ_DEV 1

`endif

// >>> verilog/usbep_pkg.sv
package usbep_pkg;
	typedef logic [7:0] usbep_byte_t;
	typedef logic [6:0] usbep_cnt_t;
	typedef logic [31:0] usbep_word_t;
	typedef logic [1:0] usbep_irq_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WAIT = 2'b01
	} usbep_hstate_t;
endpackage

// >>> verilog/usbep_if.sv
`timescale 1ns/1ps
interface usbep_if;
	usbep_pkg::usbep_byte_t addr;
	usbep_pkg::usbep_byte_t wdata;
	logic wr;
	logic rd;
	usbep_pkg::usbep_byte_t rdata;
	logic ack;
	logic dev_evt;
	modport dev (
		input addr,
		input wdata,
		input wr,
		input rd,
		output rdata,
		output ack,
		output dev_evt
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input rdata,
		input ack,
		input dev_evt
	);
endinterface

// >>> verilog/usbep_host.sv
`timescale 1ns/1ps
`include "usbep_defines.svh"
module usbep_host (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	usbep_if.host bus,
	input wire logic [3:0] av_address,
	input wire logic av_read,
	input wire logic av_write,
	input wire usbep_pkg::usbep_word_t av_writedata,
	input wire logic [3:0] av_byteenable,
	output usbep_pkg::usbep_word_t av_readdata,
	output logic av_waitrequest,
	output logic irq
);
	import usbep_pkg::*;

	function automatic logic at(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	usbep_hstate_t st_q;
	logic wait_q;
	usbep_word_t rdd_q;
	usbep_byte_t addr_q;
	usbep_byte_t wdata_q;
	logic wr_q;
	logic rd_q;
	usbep_byte_t cap_q;
	usbep_irq_t ists_q;
	usbep_irq_t imsk_q;
	logic irq_q;

	// a write lands at the edge where waitrequest is seen low
	wire logic take_wr = av_write & ~wait_q;
	wire logic take_rd = av_read & wait_q;
	wire logic busy = st_q != HS_IDLE;
	// commands issued while busy are dropped
	wire logic launch = take_wr & at(av_address, `USBEP_AV_CMD) & ~busy & (&av_byteenable[2:0]);
	wire logic is_en = av_writedata[7:0] == `USBEP_A_ENABLE;
	wire usbep_byte_t cmd_wd = av_writedata[15:8];
	// reserved enable bit is always written as one
	wire usbep_byte_t cmd_wd_fix = is_en ? (cmd_wd | 8'h01) : cmd_wd; // [R14]
	wire logic done = (st_q == HS_WAIT) & bus.ack;
	wire logic w_ists = take_wr & at(av_address, `USBEP_AV_ISTS) & av_byteenable[0];
	wire logic w_imsk = take_wr & at(av_address, `USBEP_AV_IMSK) & av_byteenable[0];
	wire usbep_irq_t ev_set = {bus.dev_evt, done};
	wire usbep_irq_t ists_clr = w_ists ? av_writedata[1:0] : 2'h0;
	// new events win over the write-one clear
	wire usbep_irq_t ists_d = ev_set | (ists_q & ~ists_clr);
	wire usbep_irq_t imsk_d = w_imsk ? av_writedata[1:0] : imsk_q;
	wire usbep_word_t rd_mux =
		at(av_address, `USBEP_AV_STAT) ? {23'h0, busy, cap_q} :
		at(av_address, `USBEP_AV_ISTS) ? {30'h0, ists_q} :
		at(av_address, `USBEP_AV_IMSK) ? {30'h0, imsk_q} :
		32'h0;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wait_q <= 1'h1;
			rdd_q <= 32'h0;
		end else if (ce) begin
			wait_q <= ~((av_read | av_write) & wait_q);
			if (take_rd) begin
				rdd_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= HS_IDLE;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_q <= 1'h0;
			rd_q <= 1'h0;
			cap_q <= 8'h00;
		end else if (ce) begin
			wr_q <= 1'h0;
			rd_q <= 1'h0;
			case (st_q)
				HS_IDLE: begin
					if (launch) begin
						addr_q <= av_writedata[7:0];
						wdata_q <= cmd_wd_fix;
						wr_q <= av_writedata[`USBEP_CMD_WR];
						rd_q <= ~av_writedata[`USBEP_CMD_WR];
						st_q <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (bus.ack) begin
						cap_q <= bus.rdata;
						st_q <= HS_IDLE;
					end
				end
				default: st_q <= HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ists_q <= 2'h0;
			imsk_q <= 2'h0;
			irq_q <= 1'h0;
		end else if (ce) begin
			ists_q <= ists_d;
			imsk_q <= imsk_d;
			irq_q <= |(ists_d & imsk_d);
		end
	end

	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
	assign av_readdata = rdd_q;
	assign av_waitrequest = wait_q;
	assign irq = irq_q;
endmodule

// >>> verif/usbep_props.sv
`timescale 1ns/1ps
module usbep_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire usbep_pkg::usbep_byte_t addr,
	input wire usbep_pkg::usbep_byte_t wdata,
	input wire logic wr,
	input wire logic rd,
	input wire usbep_pkg::usbep_byte_t rdata,
	input wire logic ack,
	input wire logic dev_evt
);
	import usbep_pkg::*;
	logic [1:0] idx_q;
	logic rd_q;
	logic req_q;
	wire rdack = ack && rd_q;
	wire idx0 = idx_q == 2'h0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// shadow of the index, so that banked reads can be judged
	always_ff @(posedge sys_clk) begin
		rd_q <= !rst && rd;
		req_q <= !rst && (rd || wr);
		if (rst)
			idx_q <= 2'h0;
		else if (wr && addr == 8'h0E)
			idx_q <= wdata[1:0];
	end
	req_answer_a: assert property ((wr || rd) |=> ack)
		else $error("request not answered");
	ack_cause_a: assert property (ack |-> req_q)
		else $error("answer without request");
	req_excl_a: assert property (!(wr && rd) && !(req_q && (wr || rd)))
		else $error("strobes overlap");
	rdata_hold_a: assert property (!rd_q |-> $stable(rdata))
		else $error("read data moved");
	cnt_top_a: assert property (rdack && addr == 8'h16 |-> !rdata[7])
		else $error("count bit 7 set");
	en_fixed_a: assert property (rdack && addr == 8'h1E |-> rdata[7:4] == 4'hF && rdata[0])
		else $error("enable fixed bits wrong");
	host_rsv_a: assert property (wr && addr == 8'h1E |-> wdata[0])
		else $error("reserved enable bit written low");
	svc_zero_a: assert property (rdack && idx0 && addr == 8'h11 |-> rdata[7:6] == 2'h0)
		else $error("service bits read back");
	idx_blank_a: assert property (rdack && idx0 && addr inside {8'h12, 8'h14, 8'h15}
		|-> rdata == 8'h00) else $error("bank register visible at index 0");
	cover property (rdack && addr == 8'h16);
	cover property (wr && addr == 8'h1E);
	cover property (dev_evt);
endmodule

// >>> verif/usb_endpoint_control_status_tb.sv
`timescale 1ns/1ps
module usb_endpoint_control_status_tb;
	import usbep_pkg::*;
	logic sys_clk, rst, irq, av_read, av_write, av_waitrequest;
	logic ep0_out_ready, ep0_in_ready, ep0_stall;
	logic ce;
	logic [3:0] av_address;
	logic [5:0] evs;
	logic [3:1] ep_live, ep_in_pipe, ep_out_pipe;
	usbep_cnt_t rx_count;
	usbep_word_t av_writedata, av_readdata, s;
	usbep_byte_t q;
	int err_count, checks_done;
	usbep_if lnk();
	usbep_dev i_usbep_dev (.sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(lnk.dev),
		.ev_setup(evs[0]), .ev_out_rx(evs[1]), .rx_count(rx_count), .ev_in_sent(evs[2]),
		.ev_in_overwrite(evs[3]), .ev_stall_sent(evs[4]), .ev_ctrl_end(evs[5]),
		.ep0_out_ready(ep0_out_ready), .ep0_in_ready(ep0_in_ready), .ep0_stall(ep0_stall),
		.ep_live(ep_live), .ep_in_pipe(ep_in_pipe), .ep_out_pipe(ep_out_pipe));
	usbep_host i_usbep_host (.sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(lnk.host),
		.av_address(av_address), .av_read(av_read), .av_write(av_write),
		.av_writedata(av_writedata), .av_byteenable(4'hF), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest), .irq(irq));
	usbep_props i_usbep_props (.sys_clk(sys_clk), .rst(rst), .addr(lnk.addr),
		.wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .ack(lnk.ack),
		.dev_evt(lnk.dev_evt));
	initial begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		checks_done++;
		if (v !== e) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, v, e);
		end
	endtask
	task automatic av(input logic [3:0] a, input logic w, input usbep_word_t d);
		int n;
		n = 0;
		@(posedge sys_clk);
		av_address <= a;
		av_write <= w;
		av_read <= !w;
		av_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (av_waitrequest !== 1'h0 && n < 40);
		if (av_waitrequest !== 1'h0) begin
			err_count++;
			$display("[ERR] %0t no answer on avalon", $time);
		end
		s = av_readdata;
		av_write <= 1'h0;
		av_read <= 1'h0;
	endtask
	// the command is launched, then status is polled until the link goes idle
	task automatic dv(input usbep_byte_t a, input logic w, input usbep_byte_t d);
		av(4'h0, 1'h1, {15'h0, w, d, a});
		repeat (20) begin
			av(4'h4, 1'h0, 32'h0);
			if (s[8] === 1'h0) break;
		end
		if (s[8] !== 1'h0) begin
			err_count++;
			$display("[ERR] %0t link stuck busy", $time);
		end
		q = s[7:0];
	endtask
	task automatic w8(input usbep_byte_t a, input usbep_byte_t d);
		dv(a, 1'h1, d);
	endtask
	task automatic r8(input usbep_byte_t a);
		dv(a, 1'h0, 8'h00);
	endtask
	task automatic ev(input int k, input usbep_cnt_t c);
		@(posedge sys_clk);
		evs <= 6'h01 << k;
		rx_count <= c;
		@(posedge sys_clk);
		evs <= 6'h00;
		#1;
	endtask
	task automatic t_rst;
		chk(ep_live, 3'h7);
		r8(8'h1E);
		chk(q, 8'hFF);
	endtask
	task automatic t_out;
		ev(1, 7'h7F);
		chk(ep0_out_ready, 1'h1);
		r8(8'h16);
		chk(q, 8'h7F);
		w8(8'h16, 8'h00);
		r8(8'h16);
		chk(q, 8'h7F);
		w8(8'h11, 8'h40);
		chk(ep0_out_ready, 1'h0);
	endtask
	task automatic t_se;
		ev(5, 7'h00);
		r8(8'h11);
		chk(q[4], 1'h1);
		w8(8'h11, 8'h80);
		r8(8'h11);
		chk(q[4], 1'h0);
		w8(8'h11, 8'h08);
		ev(5, 7'h00);
		r8(8'h11);
		chk(q[4:3], 2'h0);
	endtask
	task automatic t_stall;
		w8(8'h11, 8'h20);
		chk(ep0_stall, 1'h1);
		ev(4, 7'h00);
		r8(8'h11);
		chk({ep0_stall, q[2]}, 2'h1);
		w8(8'h11, 8'h00);
		r8(8'h11);
		chk(q[2], 1'h0);
	endtask
	task automatic t_in;
		int k[3] = '{2, 0, 3};
		av(4'hC, 1'h1, 32'h2);
		foreach (k[i]) begin
			w8(8'h11, 8'h02);
			chk(ep0_in_ready, 1'h1);
			av(4'h8, 1'h1, 32'h3);
			ev(k[i], 7'h08);
			av(4'h8, 1'h0, 32'h0);
			chk({ep0_in_ready, s[1], irq}, 3'h3);
		end
		av(4'h8, 1'h1, 32'h3);
		av(4'hC, 1'h1, 32'h0);
		chk(irq, 1'h0);
		ev(0, 7'h08);
		av(4'h8, 1'h0, 32'h0);
		chk({s[1], irq}, 2'h2);
	endtask
	task automatic t_ep;
		for (int i = 1; i < 4; i++) begin
			w8(8'h0E, 8'(i));
			w8(8'h15, 8'(i) | 8'hA0);
			w8(8'h12, 8'h20);
			chk({ep_in_pipe[i], ep_out_pipe[i]}, 2'h2);
			w8(8'h12, 8'h00);
			chk({ep_in_pipe[i], ep_out_pipe[i]}, 2'h1);
			w8(8'h12, 8'h04);
			chk({ep_in_pipe[i], ep_out_pipe[i]}, 2'h3);
		end
		for (int i = 1; i < 4; i++) begin
			w8(8'h0E, 8'(i));
			r8(8'h15);
			chk(q, 8'(i) | 8'hA0);
		end
		w8(8'h0E, 8'h00);
		r8(8'h12);
		chk(q, 8'h00);
		w8(8'h1E, 8'hFA);
		chk({ep_live, ep_in_pipe[2], ep_out_pipe[2]}, 5'h14);
		r8(8'h1E);
		chk(q, 8'hFB);
		r8(8'h30);
		chk(q, 8'h00);
	endtask
	// a frozen block must neither take an event nor latch a new count
	task automatic t_ce;
		w8(8'h11, 8'h40);
		@(posedge sys_clk);
		ce <= 1'h0;
		ev(1, 7'h11);
		chk(ep0_out_ready, 1'h0);
		@(posedge sys_clk);
		ce <= 1'h1;
		r8(8'h16);
		av(4'h8, 1'h0, 32'h0);
		chk({q, s[0]}, 9'h011);
	endtask
	task automatic end_sim;
		$display("err_count=%0d checks_done=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		end_sim;
	end
	initial begin
		rst = 1'h1;
		ce = 1'h1;
		evs = 6'h00;
		rx_count = 7'h00;
		av_address = 4'h0;
		av_read = 1'h0;
		av_write = 1'h0;
		av_writedata = 32'h0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'h0;
		t_rst;
		t_out;
		t_se;
		t_stall;
		t_in;
		t_ep;
		t_ce;
		end_sim;
	end
endmodule
